/* inc/ufrc_pkg.sv */
// Constants and types shared by the serial port core
package ufrc_pkg;
	// Register offsets
	localparam logic [2:0] ADDR_DATA = 3'h0;
	localparam logic [2:0] ADDR_IER = 3'h1;
	localparam logic [2:0] ADDR_IIR = 3'h2;
	localparam logic [2:0] ADDR_LCR = 3'h3;
	localparam logic [2:0] ADDR_MCR = 3'h4;
	localparam logic [2:0] ADDR_LSR = 3'h5;
	localparam logic [2:0] ADDR_MSR = 3'h6;
	localparam logic [2:0] ADDR_SCR = 3'h7;
	////////////////////////////////////////////////////////////////
	// Field positions
	localparam int LCR_DIV_SEL = 7;
	localparam int LCR_BREAK = 6;
	localparam int LCR_STICK = 5;
	localparam int LCR_EVEN = 4;
	localparam int LCR_PAR_EN = 3;
	localparam int LCR_STOP2 = 2;
	localparam int FCR_ENABLE = 0;
	localparam int FCR_RX_RST = 1;
	localparam int FCR_TX_RST = 2;
	localparam int FCR_TRIG_LO = 6;
	localparam int MCR_LOOP = 4;
	localparam int IER_RX = 0;
	localparam int IER_TX = 1;
	localparam int IER_LINE = 2;
	localparam int IER_MODEM = 3;
	////////////////////////////////////////////////////////////////
	// Identification codes
	localparam logic [3:0] IIR_NONE = 4'h1;
	localparam logic [3:0] IIR_LINE = 4'h6;
	localparam logic [3:0] IIR_RXDATA = 4'h4;
	localparam logic [3:0] IIR_TIMEOUT = 4'hc;
	localparam logic [3:0] IIR_TX_HOLD_EMPTY_FLAG = 4'h2;
	localparam logic [3:0] IIR_MODEM = 4'h0;
	// Receive trigger levels
	localparam logic [4:0] TRIG_L0 = 5'h01;
	localparam logic [4:0] TRIG_L1 = 5'h04;
	localparam logic [4:0] TRIG_L2 = 5'h08;
	localparam logic [4:0] TRIG_L3 = 5'h0e;
	////////////////////////////////////////////////////////////////
	// Timing: 16 baud ticks per bit, sample at mid bit
	localparam int OVS = 16;
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] OVS_MID = 4'h7;
	localparam int TMO_CHARS = 4;
	// Reset values
	localparam logic [5:0] SYNC_RESET = 6'h1f;
	localparam logic [7:0] LCR_RESET = 8'h00;
	localparam logic [4:0] MCR_RESET = 5'h00;
	localparam logic [3:0] IER_RESET = 4'h0;
	////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] wdata;
	} ufrc_bus_t;
	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP, ST_HOLD} ufrc_state_t;
endpackage

/* hdl/ufrc_core.sv */
// Serial port core: host registers, FIFOs, transmitter and receiver
// Function
// - Divisor select bit maps offsets 0 and 1 onto divisor bytes.
// - Characters are shifted least significant bit first both ways.
// - Legacy mode: all-empty flag follows the shift register only.
// - Legacy mode: scratch byte is not available.
// - Without FIFOs, FIFO, timeout and FIFO error indicator bits read zero.
// - DMA mode select bit has no effect.
// - Receive FIFO holds sixteen bytes in FIFO mode, one without, whatever the trigger level.
// - Transmitter starts by itself once a byte is in the FIFO.
// - Writes refused while transmit FIFO full, accepted after next load.
// - Transmit interrupt when FIFO empty and enabled, except load delay.
// - First byte into an empty transmit FIFO drops the interrupt.
// - After a first load, renewed interrupt waits one character time.
// - The delay holds until two bytes sat in the FIFO together.
// - After that, the next emptying raises the interrupt at once.
// - Receive interrupt when count reaches trigger level and enabled.
// - Full receive FIFO takes nothing more; next character sets overrun.
// - Timeout interrupt after four idle character times with data waiting.
// - Host read or new byte clears timeout and restarts its timer.
// - Identification reads 01 after reset.
// - Line status reads 60 after reset.
// - Line status interrupt outranks received data interrupt.
// - Holding write or identification read clears transmit interrupt.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module ufrc_fifo import ufrc_pkg::*; #(
	parameter int W = 8,
	parameter int DEPTH = 16,
	localparam int PW = $clog2(DEPTH),
	localparam int CW = PW + 1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Control
	input wire logic clr,
	input wire logic [CW-1:0] cap,
	// Write side
	input wire logic push,
	input wire logic [W-1:0] wdata,
	// Read side
	input wire logic pop,
	output logic [W-1:0] head,
	output logic [CW-1:0] cnt_q
);
	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wp_q;
	logic [PW-1:0] rp_q;
	wire logic do_push = push && cnt_q < cap;
	wire logic do_pop = pop && cnt_q != '0;
	assign head = mem[rp_q];
	always_ff @(posedge clk) begin
		if (do_push) begin
			mem[wp_q] <= wdata;
		end
	end
	always_ff @(posedge clk) begin
		if (!nrst || clr) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_q + PW'(do_push);
			rp_q <= rp_q + PW'(do_pop);
			cnt_q <= cnt_q + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule
////////////////////////////////////////////////////////////////////////
module ufrc_core import ufrc_pkg::*; #(
	parameter int FIFO_DEPTH = 16
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Host register port
	input wire ufrc_bus_t host_req,
	output logic [7:0] host_rdata_q,
	output logic irq_q,
	// Mode strap
	input wire logic legacy_pc_mode,
	// Serial line
	input wire logic rxd,
	output logic txd_q,
	// Modem inputs, active low
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic dcd_n,
	// Modem outputs, active low
	output logic dtr_n_q,
	output logic rts_n_q,
	output logic out1_n_q,
	output logic out2_n_q
);
	localparam int CW = $clog2(FIFO_DEPTH) + 1;
	if (FIFO_DEPTH < 16 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("FIFO_DEPTH must be a power of two of at least 16");
	end

	function automatic logic par_of(input logic [7:0] d, input logic [7:0] line_format);
		logic [7:0] m;
		m = 8'hff >> (2'h3 - line_format[1:0]);
		par_of = line_format[LCR_STICK] ? ~line_format[LCR_EVEN] : (^(d & m)) ^ ~line_format[LCR_EVEN];
	endfunction

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [5:0] sync1_q;
	logic [5:0] sync2_q;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			sync1_q <= SYNC_RESET;
			sync2_q <= SYNC_RESET;
		end else begin
			sync1_q <= {legacy_pc_mode, dcd_n, ri_n, dsr_n, cts_n, rxd};
			sync2_q <= sync1_q;
		end
	end
	wire logic rxd_s = sync2_q[0];
	wire logic legacy = sync2_q[5];

	////////////////////////////////////////////////////////////////
	// Host registers and decode
	logic [3:0] ier_q;
	logic [7:0] lcr_q;
	logic [4:0] mcr_q;
	logic fifo_en_q;
	logic [1:0] trig_q;
	logic [7:0] dll_q;
	logic [7:0] dlm_q;
	logic [7:0] scr_q;
	wire logic [7:0] wd = host_req.wdata;
	wire logic [2:0] ad = host_req.addr;
	wire logic dsel = lcr_q[LCR_DIV_SEL];
	wire logic loop = mcr_q[MCR_LOOP];
	wire logic wr_thr = host_req.wr && ad == ADDR_DATA && !dsel;
	wire logic wr_dll = host_req.wr && ad == ADDR_DATA && dsel;
	wire logic wr_ier = host_req.wr && ad == ADDR_IER && !dsel;
	wire logic wr_dlm = host_req.wr && ad == ADDR_IER && dsel;
	wire logic wr_fcr = host_req.wr && ad == ADDR_IIR;
	wire logic wr_lcr = host_req.wr && ad == ADDR_LCR;
	wire logic wr_mcr = host_req.wr && ad == ADDR_MCR;
	wire logic wr_scr = host_req.wr && ad == ADDR_SCR && !legacy;
	wire logic rd_rbr = host_req.rd && ad == ADDR_DATA && !dsel;
	wire logic rd_iir = host_req.rd && ad == ADDR_IIR;
	wire logic rd_lsr = host_req.rd && ad == ADDR_LSR;
	wire logic rd_msr = host_req.rd && ad == ADDR_MSR;
	// Enable change empties both FIFOs, as do the self-clearing reset bits
	wire logic fcr_chg = wr_fcr && wd[FCR_ENABLE] != fifo_en_q;
	wire logic rx_clr = wr_fcr && (wd[FCR_RX_RST] || fcr_chg);
	wire logic tx_clr = wr_fcr && (wd[FCR_TX_RST] || fcr_chg);

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			ier_q <= IER_RESET;
			lcr_q <= LCR_RESET;
			mcr_q <= MCR_RESET;
			fifo_en_q <= 1'b0;
			trig_q <= 2'h0;
			dll_q <= 8'h00;
			dlm_q <= 8'h00;
			scr_q <= 8'h00;
		end else begin
			if (wr_ier) begin
				ier_q <= wd[3:0];
			end
			if (wr_dll) begin
				dll_q <= wd;
			end
			if (wr_dlm) begin
				dlm_q <= wd;
			end
			if (wr_fcr) begin
				// DMA select and reset bits are not stored
				fifo_en_q <= wd[FCR_ENABLE];
				trig_q <= wd[FCR_TRIG_LO+:2];
			end
			if (wr_lcr) begin
				lcr_q <= wd;
			end
			if (wr_mcr) begin
				mcr_q <= wd[4:0];
			end
			if (wr_scr) begin
				scr_q <= wd;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Baud tick at 16 times the bit rate; divisor zero stops it
	logic [15:0] bcnt_q;
	wire logic [15:0] divisor = {dlm_q, dll_q};
	wire logic tick = divisor != 16'h0000 && bcnt_q <= 16'h0001;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			bcnt_q <= 16'h0000;
		end else if (tick) begin
			bcnt_q <= divisor;
		end else if (divisor != 16'h0000) begin
			bcnt_q <= bcnt_q - 16'h0001;
		end
	end
	wire logic par_en = lcr_q[LCR_PAR_EN];
	wire logic [3:0] last_bit = 4'h4 + {2'h0, lcr_q[1:0]};
	wire logic [3:0] cbits = last_bit + 4'h3 + {3'h0, par_en} + {3'h0, lcr_q[LCR_STOP2]};
	wire logic [7:0] char_ticks = 8'(cbits * OVS);
	wire logic [9:0] tmo_lim = 10'(cbits * OVS * TMO_CHARS);

	////////////////////////////////////////////////////////////////
	// Transmit FIFO and shifter
	logic [7:0] tx_head;
	logic [CW-1:0] tx_cnt;
	ufrc_state_t tx_st_q;
	logic [3:0] tx_sub_q;
	logic [3:0] tx_bit_q;
	logic [7:0] tx_sh_q;
	logic tx_par_q;
	wire logic [CW-1:0] cap = fifo_en_q ? CW'(FIFO_DEPTH) : CW'(1);
	wire logic tx_full = tx_cnt >= cap;
	wire logic tx_push = wr_thr && !tx_full;
	wire logic tx_load = tick && tx_st_q == ST_IDLE && tx_cnt != '0;
	wire logic tx_empty = tx_cnt == '0;
	wire logic tx_busy = tx_st_q != ST_IDLE;
	ufrc_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
		.clk(mclk),
		.nrst(nrst),
		.clr(tx_clr),
		.cap(cap),
		.push(tx_push),
		.wdata(wd),
		.pop(tx_load),
		.head(tx_head),
		.cnt_q(tx_cnt)
	);
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			tx_st_q <= ST_IDLE;
			tx_sub_q <= 4'h0;
			tx_bit_q <= 4'h0;
			tx_sh_q <= 8'h00;
			tx_par_q <= 1'b0;
		end else if (tick) begin
			tx_sub_q <= tx_sub_q + 4'h1;
			unique case (tx_st_q)
				ST_IDLE: begin
					tx_sub_q <= 4'h0;
					if (tx_load) begin
						tx_st_q <= ST_START;
						tx_sh_q <= tx_head;
						tx_par_q <= par_of(tx_head, lcr_q);
					end
				end
				ST_START: begin
					if (tx_sub_q == OVS_LAST) begin
						tx_st_q <= ST_DATA;
						tx_bit_q <= 4'h0;
					end
				end
				ST_DATA: begin
					if (tx_sub_q == OVS_LAST) begin
						tx_sh_q <= {1'b0, tx_sh_q[7:1]};
						tx_bit_q <= tx_bit_q + 4'h1;
						if (tx_bit_q == last_bit) begin
							tx_st_q <= par_en ? ST_PAR : ST_STOP;
							tx_bit_q <= 4'h0;
						end
					end
				end
				ST_PAR: begin
					if (tx_sub_q == OVS_LAST) begin
						tx_st_q <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (tx_sub_q == OVS_LAST) begin
						if (lcr_q[LCR_STOP2] && tx_bit_q == 4'h0) begin
							tx_bit_q <= 4'h1;
						end else begin
							tx_st_q <= ST_IDLE;
						end
					end
				end
				default: begin
					tx_st_q <= ST_IDLE;
				end
			endcase
		end
	end
	wire logic tx_bitval = tx_st_q == ST_START ? 1'b0 : tx_st_q == ST_DATA ? tx_sh_q[0] :
		tx_st_q == ST_PAR ? tx_par_q : 1'b1;
	wire logic tx_line = tx_bitval && !lcr_q[LCR_BREAK];

	////////////////////////////////////////////////////////////////
	// Transmit interrupt pacing
	logic two_q;
	logic tx_hold_empty_flag_q;
	logic [7:0] dly_q;
	logic [3:0] iir_code;
	wire logic tx_drain = tx_load && tx_cnt == CW'(1) && !tx_push;
	wire logic ier_tx_rise = wr_ier && wd[IER_TX] && !ier_q[IER_TX] && tx_empty;
	wire logic dly_done = tick && dly_q == 8'h01;
	wire logic tx_hold_empty_flag_set = (tx_drain && two_q) || dly_done || ier_tx_rise || tx_clr;
	wire logic tx_hold_empty_flag_clr = tx_push || (rd_iir && iir_code == IIR_TX_HOLD_EMPTY_FLAG);
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			two_q <= 1'b0;
			tx_hold_empty_flag_q <= 1'b0;
			dly_q <= 8'h00;
		end else begin
			two_q <= (two_q && !tx_hold_empty_flag_set) || tx_cnt >= CW'(2);
			tx_hold_empty_flag_q <= tx_hold_empty_flag_set || (tx_hold_empty_flag_q && !tx_hold_empty_flag_clr);
			if (tx_push || tx_clr) begin
				dly_q <= 8'h00;
			end else if (tx_drain && !two_q) begin
				dly_q <= char_ticks;
			end else if (tick && dly_q != 8'h00) begin
				dly_q <= dly_q - 8'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Receiver
	ufrc_state_t rx_st_q;
	logic [3:0] rx_sub_q;
	logic [3:0] rx_bit_q;
	logic [7:0] rx_sh_q;
	logic rx_pbit_q;
	logic [10:0] rx_head;
	logic [CW-1:0] rx_cnt;
	wire logic rx_in = loop ? tx_line : rxd_s;
	wire logic rx_pe = par_en && rx_pbit_q != par_of(rx_sh_q, lcr_q);
	wire logic rx_brk = rx_sh_q == 8'h00 && !(par_en && rx_pbit_q) && !rx_in;
	wire logic [10:0] rx_word = {rx_brk, !rx_in, rx_pe, rx_sh_q};
	wire logic rx_push = tick && rx_st_q == ST_STOP && rx_sub_q == OVS_LAST;
	wire logic rx_full = rx_cnt >= cap;
	wire logic rx_ok = rx_push && !rx_full;
	wire logic rx_pop = rd_rbr && rx_cnt != '0;
	// Sixteen entries are kept in FIFO mode, one without; the trigger only sets the interrupt
	ufrc_fifo #(.W(11), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clk(mclk),
		.nrst(nrst),
		.clr(rx_clr),
		.cap(cap),
		.push(rx_push),
		.wdata(rx_word),
		.pop(rx_pop),
		.head(rx_head),
		.cnt_q(rx_cnt)
	);
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rx_st_q <= ST_IDLE;
			rx_sub_q <= 4'h0;
			rx_bit_q <= 4'h0;
			rx_sh_q <= 8'h00;
			rx_pbit_q <= 1'b0;
		end else if (tick) begin
			rx_sub_q <= rx_sub_q + 4'h1;
			unique case (rx_st_q)
				ST_IDLE: begin
					rx_sub_q <= 4'h0;
					if (!rx_in) begin
						rx_st_q <= ST_START;
						rx_sh_q <= 8'h00;
					end
				end
				ST_START: begin
					// A start bit gone by mid bit is a glitch
					if (rx_sub_q == OVS_MID) begin
						rx_st_q <= rx_in ? ST_IDLE : ST_DATA;
						rx_sub_q <= 4'h0;
						rx_bit_q <= 4'h0;
					end
				end
				ST_DATA: begin
					if (rx_sub_q == OVS_LAST) begin
						rx_sh_q[rx_bit_q[2:0]] <= rx_in;
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == last_bit) begin
							rx_st_q <= par_en ? ST_PAR : ST_STOP;
						end
					end
				end
				ST_PAR: begin
					if (rx_sub_q == OVS_LAST) begin
						rx_pbit_q <= rx_in;
						rx_st_q <= ST_STOP;
					end
				end
				ST_STOP: begin
					if (rx_sub_q == OVS_LAST) begin
						rx_st_q <= rx_brk ? ST_HOLD : ST_IDLE;
					end
				end
				ST_HOLD: begin
					// After a break wait for the line to go idle again
					if (rx_in) begin
						rx_st_q <= ST_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Receive timeout, line and modem status
	logic [9:0] tmo_cnt_q;
	logic tmo_q;
	logic [3:0] lsr_err_q;
	logic [CW-1:0] err_cnt_q;
	logic [3:0] msr_prev_q;
	logic [3:0] msr_delta_q;
	wire logic rx_touch = rx_push || rx_pop || rx_clr || rx_cnt == '0;
	wire logic [3:0] err_set = {4{rx_push}} & {rx_word[10:8], rx_full};
	wire logic [3:0] msr_now = loop ? {mcr_q[3], mcr_q[2], mcr_q[0], mcr_q[1]} : ~sync2_q[4:1];
	wire logic [3:0] msr_chg = {msr_now[3] ^ msr_prev_q[3], msr_prev_q[2] && !msr_now[2],
		msr_now[1:0] ^ msr_prev_q[1:0]};
	always_ff @(posedge mclk) begin
		if (!nrst || rx_touch) begin
			tmo_cnt_q <= 10'h000;
			tmo_q <= 1'b0;
		end else if (tick && fifo_en_q) begin
			if (tmo_cnt_q >= tmo_lim) begin
				tmo_q <= 1'b1;
			end else begin
				tmo_cnt_q <= tmo_cnt_q + 10'h001;
			end
		end
	end
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			lsr_err_q <= 4'h0;
			err_cnt_q <= '0;
			msr_prev_q <= 4'h0;
			msr_delta_q <= 4'h0;
		end else begin
			lsr_err_q <= err_set | (lsr_err_q & ~{4{rd_lsr}});
			msr_prev_q <= msr_now;
			msr_delta_q <= msr_chg | (msr_delta_q & ~{4{rd_msr}});
			if (rx_clr) begin
				err_cnt_q <= '0;
			end else begin
				err_cnt_q <= err_cnt_q + CW'(rx_ok && |rx_word[10:8]) - CW'(rx_pop && |rx_head[10:8]);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt identification and read mux
	wire logic [4:0] trig_sel = trig_q == 2'h0 ? TRIG_L0 : trig_q == 2'h1 ? TRIG_L1 :
		trig_q == 2'h2 ? TRIG_L2 : TRIG_L3;
	wire logic [CW-1:0] trig_lvl = fifo_en_q ? CW'(trig_sel) : CW'(1);
	wire logic line_p = |lsr_err_q && ier_q[IER_LINE];
	wire logic rx_p = rx_cnt >= trig_lvl && ier_q[IER_RX];
	wire logic tmo_p = tmo_q && ier_q[IER_RX];
	wire logic tx_hold_empty_flag_p = tx_hold_empty_flag_q && ier_q[IER_TX];
	wire logic msr_p = |msr_delta_q && ier_q[IER_MODEM];
	assign iir_code = line_p ? IIR_LINE : rx_p ? IIR_RXDATA : tmo_p ? IIR_TIMEOUT :
		tx_hold_empty_flag_p ? IIR_TX_HOLD_EMPTY_FLAG : msr_p ? IIR_MODEM : IIR_NONE;
	// Bit 3 and the top pair only show in FIFO mode
	wire logic [7:0] iir_byte = {{2{fifo_en_q}}, 2'h0, iir_code & {fifo_en_q, 3'h7}};
	wire logic all_empty = legacy ? !tx_busy : tx_empty && !tx_busy;
	wire logic [7:0] lsr_byte = {fifo_en_q && err_cnt_q != '0, all_empty, tx_empty,
		lsr_err_q, rx_cnt != '0};
	wire logic [7:0] rd_mux [8];
	assign rd_mux[0] = dsel ? dll_q : rx_head[7:0];
	assign rd_mux[1] = dsel ? dlm_q : {4'h0, ier_q};
	assign rd_mux[2] = iir_byte;
	assign rd_mux[3] = lcr_q;
	assign rd_mux[4] = {3'h0, mcr_q};
	assign rd_mux[5] = lsr_byte;
	assign rd_mux[6] = {msr_now, msr_delta_q};
	assign rd_mux[7] = legacy ? 8'h00 : scr_q;

	////////////////////////////////////////////////////////////////
	// Registered outputs; loopback holds the pins inactive
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			host_rdata_q <= 8'h00;
			irq_q <= 1'b0;
			txd_q <= 1'b1;
			dtr_n_q <= 1'b1;
			rts_n_q <= 1'b1;
			out1_n_q <= 1'b1;
			out2_n_q <= 1'b1;
		end else begin
			if (host_req.rd) begin
				host_rdata_q <= rd_mux[ad];
			end
			irq_q <= iir_code != IIR_NONE;
			txd_q <= loop || tx_line;
			dtr_n_q <= !(mcr_q[0] && !loop);
			rts_n_q <= !(mcr_q[1] && !loop);
			out1_n_q <= !(mcr_q[2] && !loop);
			out2_n_q <= !(mcr_q[3] && !loop);
		end
	end
endmodule

/* verif/ufrc_core_properties.sv */
// Concurrent checks on the serial port core host and line ports
`timescale 1ns/1ps
module ufrc_core_properties import ufrc_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Host side
	input wire ufrc_bus_t host_req,
	input wire logic [7:0] host_rdata_q,
	input wire logic irq_q,
	input wire logic legacy_pc_mode,
	// Line and modem side
	input wire logic txd_q,
	input wire logic dtr_n_q,
	input wire logic rts_n_q,
	input wire logic out1_n_q,
	input wire logic out2_n_q
);
	// Shadow copies of host writes, so read data can be judged
	logic [7:0] lcr_q;
	logic [7:0] dll_q;
	logic [7:0] dlm_q;
	logic [3:0] ier_q;
	logic fen_q;
	logic [4:0] mcr_q;
	wire logic dl_sel = lcr_q[LCR_DIV_SEL];
	wire logic rd_iir = host_req.rd && host_req.addr == ADDR_IIR;
	wire logic rd_data = host_req.rd && host_req.addr == ADDR_DATA;
	wire logic rd_ier = host_req.rd && host_req.addr == ADDR_IER;
	wire logic wr_data = host_req.wr && host_req.addr == ADDR_DATA;
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			lcr_q <= 8'h00;
			dll_q <= 8'h00;
			dlm_q <= 8'h00;
			ier_q <= 4'h0;
			fen_q <= 1'b0;
			mcr_q <= 5'h00;
		end else if (host_req.wr) begin
			if (host_req.addr == ADDR_LCR) lcr_q <= host_req.wdata;
			if (host_req.addr == ADDR_DATA && dl_sel) dll_q <= host_req.wdata;
			if (host_req.addr == ADDR_IER && dl_sel) dlm_q <= host_req.wdata;
			if (host_req.addr == ADDR_IER && !dl_sel) ier_q <= host_req.wdata[3:0];
			if (host_req.addr == ADDR_IIR) fen_q <= host_req.wdata[FCR_ENABLE];
			if (host_req.addr == ADDR_MCR) mcr_q <= host_req.wdata[4:0];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!nrst);
	a_reset_outputs: assert property (disable iff (1'b0) !nrst |=> txd_q && !irq_q && host_rdata_q == 8'h00
		&& dtr_n_q && rts_n_q && out1_n_q && out2_n_q) else $error("outputs not idle after reset");
	a_div_low_read: assert property (rd_data && dl_sel |=> host_rdata_q == dll_q)
		else $error("low divisor byte not read back");
	a_div_high_read: assert property (rd_ier && dl_sel |=> host_rdata_q == dlm_q)
		else $error("high divisor byte not read back");
	a_ier_upper_zero: assert property (rd_ier && !dl_sel |=> host_rdata_q == {4'h0, ier_q})
		else $error("interrupt enable read wrong");
	a_iir_fifo_off: assert property (rd_iir && !fen_q |=> host_rdata_q[7:6] == 2'b00 && !host_rdata_q[3])
		else $error("fifo indicators set with fifos off");
	a_lsr_err_off: assert property (host_req.rd && host_req.addr == ADDR_LSR && !fen_q |=> !host_rdata_q[7])
		else $error("fifo error flag set with fifos off");
	a_legacy_scratch: assert property (host_req.rd && host_req.addr == ADDR_SCR && legacy_pc_mode
		&& $past(legacy_pc_mode, 1) && $past(legacy_pc_mode, 2) && $past(legacy_pc_mode, 3) |=> host_rdata_q == 8'h00)
		else $error("scratch visible in legacy mode");
	a_tx_hold_empty_flag_read_clear: assert property (rd_iir && ier_q == 4'h2 ##1 host_rdata_q[3:0] == IIR_TX_HOLD_EMPTY_FLAG |-> ##[1:2] !irq_q)
		else $error("transmit interrupt kept after identify read");
	a_thr_write_drop: assert property (wr_data && !dl_sel && ier_q == 4'h2 |-> ##[1:3] !irq_q)
		else $error("transmit interrupt kept after holding write");
	// Pins lag the control register by one cycle and rest high in loopback
	a_modem_pins: assert property ({dtr_n_q, rts_n_q, out1_n_q, out2_n_q}
		== ~({4{!$past(mcr_q[MCR_LOOP])}} & $past({mcr_q[0], mcr_q[1], mcr_q[2], mcr_q[3]})))
		else $error("modem outputs do not follow modem control");
	c_timeout: cover property (rd_iir ##1 host_rdata_q[3:0] == IIR_TIMEOUT);
	c_rx_trigger: cover property (rd_iir ##1 host_rdata_q[3:0] == IIR_RXDATA);
	c_div_read: cover property (rd_data && dl_sel);
endmodule

/* verif/ufrc_line_peer.sv */
// Remote serial device: sends and receives 8N1 characters on the line
`timescale 1ns/1ps
module ufrc_line_peer #(
	parameter int BIT_CYC = 16
) (
	// Clock
	input wire logic mclk,
	// Line
	input wire logic txd,
	output logic rxd,
	// Received character
	output logic [7:0] got,
	output logic got_stop,
	output logic got_stb
);
	initial begin
		rxd = 1'b1;
		got = 8'h00;
		got_stop = 1'b0;
		got_stb = 1'b0;
	end
	// Start bit, data least significant first, stop bit; line then rests high
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge mclk);
			rxd = f[i];
			repeat (BIT_CYC - 1) @(negedge mclk);
		end
	endtask
	////////////////////////////////////////////////////////////////
	// Sample mid bit; a low stop bit is reported, not hidden
	always begin
		@(negedge mclk iff (txd === 1'b0));
		repeat (BIT_CYC / 2) @(negedge mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CYC) @(negedge mclk);
			got[i] = txd;
		end
		repeat (BIT_CYC) @(negedge mclk);
		got_stop = txd;
		got_stb = 1'b1;
		@(negedge mclk);
		got_stb = 1'b0;
	end
endmodule

/* verif/ufrc_core_tb.sv */
// Self-checking bench for the serial port core
`timescale 1ns/1ps
module ufrc_core_tb import ufrc_pkg::*; ;
	// Design hookup
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic legacy_pc_mode = 1'b0;
	ufrc_bus_t host_req = '0;
	logic [7:0] host_rdata_q;
	logic irq_q;
	logic rxd;
	logic txd_q;
	logic [7:0] got_byte;
	logic got_stop;
	logic got_stb;
	// Bench state
	int err_count = 0;
	int comparisons = 0;
	int seed = 32'h1d7a;
	int cyc = 0;
	logic taken = 1'b0;
	logic [7:0] exp_q[$];
	logic [7:0] tx_q[$];
	logic [7:0] rx_b[$];
	ufrc_core #(.FIFO_DEPTH(16)) i_dut (.mclk(mclk), .nrst(nrst), .host_req(host_req), .host_rdata_q(host_rdata_q),
		.irq_q(irq_q), .legacy_pc_mode(legacy_pc_mode), .rxd(rxd), .txd_q(txd_q), .cts_n(1'b1), .dsr_n(1'b1),
		.ri_n(1'b1), .dcd_n(1'b1), .dtr_n_q(), .rts_n_q(), .out1_n_q(), .out2_n_q());
	ufrc_line_peer #(.BIT_CYC(OVS)) i_peer (.mclk(mclk), .txd(txd_q), .rxd(rxd), .got(got_byte), .got_stop(got_stop),
		.got_stb(got_stb));
	initial forever #25 mclk = ~mclk;
	////////////////////////////////////////////////////////////////
	task automatic fail(input string m);
		err_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic final_report();
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// One request per two cycles, strobe dropped in between
	task automatic op(input logic r, input logic w, input logic [2:0] a, input logic [7:0] d);
		@(negedge mclk);
		host_req = '{r, w, a, d};
		@(negedge mclk);
		host_req = '0;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		op(1'b0, 1'b1, a, d);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		op(1'b1, 1'b0, a, 8'h00);
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic put(input int n, input int keep);
		logic [7:0] b;
		for (int i = 0; i < n; i++) begin
			b = 8'($random(seed));
			if (i < keep) tx_q.push_back(b);
			wr(ADDR_DATA, b);
		end
	endtask
	task automatic drain();
		while (tx_q.size() != 0) @(negedge mclk);
	endtask
	task automatic rx_send(input int n);
		logic [7:0] b;
		repeat (n) begin
			b = 8'($random(seed));
			rx_b.push_back(b);
			i_peer.send(b);
		end
	endtask
	task automatic rx_get(input int n);
		repeat (n) rd(ADDR_DATA, rx_b.pop_front());
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge mclk) taken <= host_req.rd;
	always @(negedge mclk) begin
		if (taken) begin
			comparisons++;
			if (exp_q.size() == 0 || host_rdata_q !== exp_q[0]) fail("read data differs");
			if (exp_q.size() != 0) void'(exp_q.pop_front());
		end
	end
	always @(posedge got_stb) begin
		comparisons++;
		if (tx_q.size() == 0 || {got_stop, got_byte} !== {1'b1, tx_q[0]}) fail("line character differs");
		if (tx_q.size() != 0) void'(tx_q.pop_front());
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 40000) begin
			fail("timeout");
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] b;
		repeat (3) @(negedge mclk);
		nrst = 1'b1;
		rd(ADDR_IIR, 8'h01);
		rd(ADDR_LSR, 8'h60);
		wr(ADDR_LCR, 8'h83);
		// Low byte kept large: the divider reloads only on its own tick, so a small one would load the interim divisor
		b = 8'($random(seed)) | 8'h80;
		wr(ADDR_DATA, b);
		wr(ADDR_IER, ~b);
		rd(ADDR_DATA, b);
		rd(ADDR_IER, ~b);
		wr(ADDR_DATA, 8'h01);
		wr(ADDR_IER, 8'h00);
		wr(ADDR_LCR, 8'h03);
		b = 8'($random(seed));
		wr(ADDR_IER, b);
		rd(ADDR_IER, {4'h0, b[3:0]});
		wr(ADDR_IER, 8'h00);
		wr(ADDR_IIR, 8'h09);
		rd(ADDR_IIR, 8'hc1);
		put(3, 3);
		drain();
		// Empty interrupt pacing after single and double loads
		wr(ADDR_IER, 8'h02);
		rd(ADDR_IIR, 8'hc2);
		rd(ADDR_IIR, 8'hc1);
		put(1, 1);
		idle(40);
		rd(ADDR_IIR, 8'hc1);
		drain();
		idle(250);
		rd(ADDR_IIR, 8'hc2);
		put(3, 3);
		idle(360);
		rd(ADDR_IIR, 8'hc2);
		drain();
		wr(ADDR_IER, 8'h00);
		// One byte in the shifter plus sixteen queued; the last write is refused
		put(18, 17);
		drain();
		idle(200);
		rd(ADDR_LSR, 8'h60);
		legacy_pc_mode = 1'b1;
		idle(4);
		wr(ADDR_SCR, 8'h5a);
		rd(ADDR_SCR, 8'h00);
		// Divisor zero stops the tick, so the byte waits in the FIFO with the shifter idle
		wr(ADDR_LCR, 8'h83);
		wr(ADDR_DATA, 8'h00);
		wr(ADDR_LCR, 8'h03);
		put(1, 1);
		rd(ADDR_LSR, 8'h40);
		wr(ADDR_LCR, 8'h83);
		wr(ADDR_DATA, 8'h01);
		wr(ADDR_LCR, 8'h03);
		drain();
		legacy_pc_mode = 1'b0;
		idle(4);
		wr(ADDR_SCR, 8'ha5);
		rd(ADDR_SCR, 8'ha5);
		// Receive trigger and timeout
		wr(ADDR_IER, 8'h01);
		wr(ADDR_IIR, 8'h41);
		rx_send(3);
		idle(50);
		rd(ADDR_IIR, 8'hc1);
		idle(700);
		rd(ADDR_IIR, 8'hcc);
		rx_get(1);
		rd(ADDR_IIR, 8'hc1);
		rx_send(2);
		idle(20);
		rd(ADDR_IIR, 8'hc4);
		rx_get(4);
		rd(ADDR_LSR, 8'h60);
		// Seventeen characters into a sixteen deep FIFO
		wr(ADDR_IER, 8'h00);
		wr(ADDR_IIR, 8'hc1);
		rx_send(17);
		rd(ADDR_IIR, 8'hc1);
		rd(ADDR_LSR, 8'h63);
		void'(rx_b.pop_back());
		rx_get(16);
		rd(ADDR_LSR, 8'h60);
		// Internal loopback: the receiver hears the transmitter while the pins rest
		wr(ADDR_MCR, 8'h1f);
		idle(2);
		rd(ADDR_MSR, 8'hfb);
		b = 8'($random(seed));
		rx_b.push_back(b);
		wr(ADDR_DATA, b);
		idle(200);
		rx_get(1);
		wr(ADDR_MCR, 8'h03);
		idle(20);
		final_report();
	end
endmodule
bind ufrc_core ufrc_core_properties i_props (.mclk(mclk), .nrst(nrst), .host_req(host_req),
	.host_rdata_q(host_rdata_q), .irq_q(irq_q), .legacy_pc_mode(legacy_pc_mode), .txd_q(txd_q),
	.dtr_n_q(dtr_n_q), .rts_n_q(rts_n_q), .out1_n_q(out1_n_q), .out2_n_q(out2_n_q));
